// File: design/vms_fifo.sv
// Byte FIFO between the flash stream and the sequence interpreter.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ns
module vms_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Honest flags straight from the fill count
	assign in_ready  = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage is written only, never reset
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// Pointers and count
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || flush)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : vms_fifo

// File: design/vms_pkg.sv
// Shared constants, carriers and helpers of the voice message sequencer.
// Assumes a 50 MHz ref_clk, a host serial link and an external serial flash.
package vms_pkg;

	// Clock rates in MHz: the wait timer counts 6 MHz system ticks
	localparam logic [5:0]  REF_MHZ         = 6'd50;
	localparam logic [5:0]  SYS_MHZ         = 6'd6;

	// Host frame opcodes and command layout
	localparam logic [7:0]  OP_PORT_READ    = 8'h49;
	localparam logic [7:0]  OP_PORT_WRITE   = 8'h4F;
	localparam logic [7:0]  OP_PLAY         = 8'h50;
	localparam logic [7:0]  OP_WAIT         = 8'h57;
	localparam logic [1:0]  FRAME_LAST_IDX  = 2'd2;

	// Test ports and the wait timer prescale register
	localparam logic [7:0]  PORT_TEST_A     = 8'h01;
	localparam logic [7:0]  TEST_A_VALUE    = 8'h42;
	localparam logic [7:0]  PORT_TEST_B     = 8'h02;
	localparam logic [7:0]  TEST_B_VALUE    = 8'h03;
	localparam logic [7:0]  ADDR_PRESCALE   = 8'h96;
	localparam logic [7:0]  PRESCALE_RESET  = 8'h81;
	localparam logic [4:0]  PERIOD_EXP_OFS  = 5'd9;

	// Flash layout
	localparam logic [23:0] PROG_FLAG_ADDR  = 24'h000000;
	localparam logic [7:0]  PROG_FLAG_VALUE = 8'h02;
	localparam logic [23:0] SOUND_BASE      = 24'h008000;
	localparam logic [3:0]  ENTRY_BYTES     = 4'h8;
	localparam logic [7:0]  BANK_UNUSED     = 8'h00;
	localparam logic [7:0]  TYPE_NONE       = 8'h00;
	localparam logic [7:0]  TYPE_SPEECH     = 8'h01;
	localparam logic [7:0]  TYPE_ADPCM      = 8'h02;
	localparam logic [7:0]  TYPE_VMSEQ      = 8'h40;

	// Flash link: read opcode, ref_clk cycles per half serial clock
	localparam logic [7:0]  FLASH_READ_OP   = 8'h03;
	localparam logic [2:0]  FLASH_HALF      = 3'd4;
	localparam int          FIFO_DEPTH      = 8;

	// One three-byte host frame, first byte on top
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] arg1;
		logic [7:0] arg2;
	} vms_cmd_s;

	// One decoded sound index entry
	typedef struct packed {
		logic [7:0]  dtype;
		logic [23:0] size;
		logic [23:0] start;
	} vms_entry_s;

	// Basic period in system ticks: two to the (nibble plus offset)
	function automatic logic [24:0] vms_period_len(input logic [3:0] nib);
		return 25'h0000001 << (5'({1'b0, nib}) + PERIOD_EXP_OFS);
	endfunction : vms_period_len

endpackage : vms_pkg

// File: design/vms_spi_slave.sv
// Host side serial slave: three-flop pin sampling, byte assembly, reply.
// Assumes the host keeps each clock level well over three ref_clk cycles.
`timescale 1ns/1ns
module vms_spi_slave (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             ssb_n,
	input  wire logic             sck,
	input  wire logic             mosi,
	input  wire vms_pkg::vms_cmd_s reply,
	output logic           [7:0]  rx_byte,
	output logic                  rx_valid,
	output logic           [1:0]  rx_idx,
	output logic                  miso,
	output logic                  miso_oe
);
	import vms_pkg::*;

	logic [2:0] ss_s, ck_s, mo_s;
	logic       ss_q, ck_q;
	logic       ss_ok, ck_ok, ck_rise, ck_fall;
	logic [2:0] bit_q;
	logic [1:0] byte_q;
	logic [6:0] sh_q;
	logic [22:0] tx_q;

	// Pin synchronisers; only the second and third stages are judged
	always_ff @(posedge ref_clk)
	begin
		ss_s <= {ss_s[1:0], ssb_n};
		ck_s <= {ck_s[1:0], sck};
		mo_s <= {mo_s[1:0], mosi};
	end

	// A level change counts once stages two and three agree
	assign ss_ok   = (ss_s[1] == ss_s[2]) ? ss_s[2] : ss_q;
	assign ck_ok   = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_q;
	assign ck_rise = ck_ok && !ck_q && !ss_ok;
	assign ck_fall = !ck_ok && ck_q && !ss_ok;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ss_q <= 1'b1;
			ck_q <= 1'b0;
		end
		else
		begin
			ss_q <= ss_ok;
			ck_q <= ck_ok;
		end
	end

	// Receive: data is taken as the clock goes high, MSB first (see R01)
	always_ff @(posedge ref_clk)
	begin
		rx_valid <= 1'b0;
		if (!rst_n || ss_ok)
		begin
			bit_q  <= 3'h0;
			byte_q <= 2'h0;
			sh_q   <= 7'h00;
			if (!rst_n)
			begin
				rx_byte <= 8'h00;
				rx_idx  <= 2'h0;
			end
		end
		else if (ck_rise)
		begin
			sh_q  <= {sh_q[5:0], mo_s[2]};
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7)
			begin
				rx_byte  <= {sh_q, mo_s[2]};
				rx_valid <= 1'b1;
				// Index names the byte handed over; bytes past the
				// third keep index 3 and are ignored upstream
				rx_idx   <= byte_q;
				if (byte_q != 2'h3)
					byte_q <= byte_q + 2'h1;
			end
		end
	end

	// Reply: snapshot at frame start, next bit after each falling clock
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			miso    <= 1'b0;
			miso_oe <= 1'b0;
			tx_q    <= 23'h000000;
		end
		else if (ss_q && !ss_ok)
		begin
			miso    <= reply.op[7];
			miso_oe <= 1'b1;
			tx_q    <= {reply.op[6:0], reply.arg1, reply.arg2};
		end
		else if (ss_ok)
			miso_oe <= 1'b0;
		else if (ck_fall)
		begin
			miso <= tx_q[22];
			tx_q <= {tx_q[21:0], 1'b0};
		end
	end

endmodule : vms_spi_slave

// File: design/vms_top.sv
// Voice message sequencer: host frames, index walk, sequence interpreter.
// Assumes decoders raise their busy flag the cycle after a start pulse.
`timescale 1ns/1ns
// Function
// R01: Serial bytes go MSB first, data valid and sampled while clock high.
// R02: Second read frame addressing port 0x01 returns 0x42 in byte two.
// R03: Second read frame addressing port 0x02 returns 0x03.
// R04: After a read, frames return selected ports; before, the play status.
// R05: A sequence bank runs its stored play commands in order.
// R06: Wait is honoured only inside a sequence, never from the host.
// R07: Wait first holds for playback end, then NN basic periods.
// R08: Speech and ADPCM plays without wait start together.
// R09: A later play of the same codec replaces the earlier one.
// R10: Basic period is 2 to the (prescale nibble plus 9) system ticks.
// R11: Prescale register resets to 0x81.
// R12: Port write stores value at address; prescale lives at 0x96.
// R13: Flash below 0x8000 is program area; sound starts at 0x8000.
// R14: Flash byte zero equal to 0x02 flags custom code.
// R15: 256 eight-byte entries from 0x8000, entry at base plus bank times 8.
// R16: Entry zero is unused and never played.
// R17: Entry bytes 0 to 2 are the start address, low byte first.
// R18: Entry bytes 4 to 6 are the data size, low byte first.
// R19: Type byte: 0 undefined, 1 speech, 2 ADPCM, 0x40 sequence.
// R20: A sequence ends when its size is consumed or on undefined type.
module vms_top (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              spi_ssb_n,
	input  wire logic              spi_sck,
	input  wire logic              spi_mosi,
	output logic                   spi_miso,
	output logic                   spi_miso_oe,
	output logic                   flash_cs_n,
	output logic                   flash_sck,
	output logic                   flash_mosi,
	input  wire logic              flash_miso,
	input  wire logic              spch_busy,
	input  wire logic              adpcm_busy,
	output logic                   spch_start,
	output logic                   adpcm_start,
	output vms_pkg::vms_entry_s    play_entry,
	output logic                   custom_code
);
	import vms_pkg::*;

	typedef enum {S_BOOT, S_BOOT_W, S_IDLE, S_IDX, S_IDX_W, S_DISPATCH,
		S_VM_GET, S_WAIT_PLAY, S_WAIT_TIME} vms_seq_e;
	typedef enum {F_IDLE, F_ADDR, F_DATA} vms_flash_e;

	vms_seq_e   st_q;
	vms_flash_e fst_q;
	vms_cmd_s   frame_q, reply_q, cmd_w;
	vms_entry_s ent_w;
	logic [7:0]  rx_byte, status, fifo_data, vm_op_q, vm_arg_q, bank_q;
	logic [7:0]  prescale_q, play_bank_q, rd_a_q, rd_b_q, nn_q, f_rx_q;
	logic [1:0]  rx_idx, vm_nb_q;
	logic        rx_valid, cmd_v, rd_armed_q, play_pend_q, play_take;
	logic        in_vm_q, vm_load, vm_end, pop, fifo_valid, fifo_ready;
	logic        seq_req, stream_ok, tick_f, f_byte_done, f_dst_q, f_done_q;
	logic        f_push_q, sys_tick, fm_q;
	logic [63:0] ent_q;
	logic [31:0] f_sh_q, f_word;
	logic [23:0] seq_addr, vm_addr_q, vm_push_q, vm_pop_q;
	logic [4:0]  f_bit_q;
	logic [3:0]  f_cnt_q;
	logic [2:0]  fdiv_q, fm_s;
	logic [5:0]  acc_q;
	logic [24:0] per_q;

	vms_spi_slave u_spi (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ssb_n    (spi_ssb_n),
		.sck      (spi_sck),
		.mosi     (spi_mosi),
		.reply    (reply_q),
		.rx_byte  (rx_byte),
		.rx_valid (rx_valid),
		.rx_idx   (rx_idx),
		.miso     (spi_miso),
		.miso_oe  (spi_miso_oe)
	);

	// Value of one port as seen by a read frame
	function automatic logic [7:0] port_value(input logic [7:0] a,
		input logic [7:0] st, input logic [7:0] ps);
		if (a == PORT_TEST_A)
			return TEST_A_VALUE;
		else if (a == PORT_TEST_B)
			return TEST_B_VALUE;
		else if (a == ADDR_PRESCALE)
			return ps;
		else
			return st;
	endfunction : port_value

	// Frame assembly: third byte completes a command
	assign cmd_w  = '{op: frame_q.op, arg1: frame_q.arg1, arg2: rx_byte};
	assign cmd_v  = rx_valid && rx_idx == FRAME_LAST_IDX;
	assign status = {5'h00, in_vm_q, adpcm_busy, spch_busy};
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			frame_q <= '0;
		else if (rx_valid && rx_idx == 2'h0)
			frame_q.op <= rx_byte;
		else if (rx_valid && rx_idx == 2'h1)
			frame_q.arg1 <= rx_byte;
	end

	// Host commands; a wait opcode from the host falls through (see R06)
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rd_armed_q <= 1'b0;
			rd_a_q     <= 8'h00;
			rd_b_q     <= 8'h00;
			prescale_q <= PRESCALE_RESET; // see R11
		end
		else if (cmd_v && cmd_w.op == OP_PORT_READ)
		begin
			rd_armed_q <= 1'b1;
			rd_a_q     <= cmd_w.arg1;
			rd_b_q     <= cmd_w.arg2;
		end
		else if (cmd_v && cmd_w.op == OP_PORT_WRITE
			&& cmd_w.arg1 == ADDR_PRESCALE)
			prescale_q <= cmd_w.arg2; // see R12
	end

	// Reply bytes two and three: ports once armed, play status until then (see R04)
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			reply_q <= '0;
		else if (rd_armed_q)
			reply_q <= '{op: status,
				arg1: port_value(rd_a_q, status, prescale_q), // see R02 R03
				arg2: port_value(rd_b_q, status, prescale_q)};
		else
			reply_q <= '{op: status, arg1: status, arg2: status};
	end

	// Pending host play; a new request wins over the take in one cycle
	assign play_take = st_q == S_IDLE && play_pend_q;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			play_pend_q <= 1'b0;
			play_bank_q <= 8'h00;
		end
		else if (cmd_v && cmd_w.op == OP_PLAY)
		begin
			play_pend_q <= 1'b1;
			play_bank_q <= cmd_w.arg1;
		end
		else if (play_take)
			play_pend_q <= 1'b0;
	end

	// Flash requests: boot flag byte, or one index entry (see R13 R15)
	assign seq_req  = (st_q == S_BOOT || st_q == S_IDX) && fst_q == F_IDLE;
	assign seq_addr = (st_q == S_BOOT) ? PROG_FLAG_ADDR
		: SOUND_BASE + {13'h0000, bank_q, 3'h0};
	assign stream_ok = in_vm_q && vm_push_q != 24'h0
		&& (st_q == S_VM_GET || st_q == S_WAIT_PLAY || st_q == S_WAIT_TIME);
	assign f_word      = {FLASH_READ_OP, seq_req ? seq_addr : vm_addr_q};
	assign tick_f      = fdiv_q == FLASH_HALF - 3'h1;
	assign f_byte_done = fst_q == F_DATA && tick_f && flash_sck
		&& f_bit_q == 5'h07;

	// Flash data pin: same three-flop agreement as the host select and clock pins
	always_ff @(posedge ref_clk)
	begin
		fm_s <= {fm_s[1:0], flash_miso};
		if (!rst_n)
			fm_q <= 1'b0;
		else if (fm_s[1] == fm_s[2])
			fm_q <= fm_s[2];
	end

	// Serial clock divider, idle while deselected
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || fst_q == F_IDLE || tick_f)
			fdiv_q <= 3'h0;
		else
			fdiv_q <= fdiv_q + 3'h1;
	end

	// Flash master: mode 0 read, stream pauses at byte edges when full
	always_ff @(posedge ref_clk)
	begin
		f_done_q <= 1'b0;
		f_push_q <= 1'b0;
		if (!rst_n)
		begin
			fst_q      <= F_IDLE;
			flash_cs_n <= 1'b1;
			flash_sck  <= 1'b0;
			flash_mosi <= 1'b0;
			f_sh_q     <= 32'h00000000;
			f_bit_q    <= 5'h00;
			f_cnt_q    <= 4'h0;
			f_dst_q    <= 1'b0;
			f_rx_q     <= 8'h00;
		end
		else case (fst_q)
			F_IDLE:
				if (seq_req || stream_ok)
				begin
					fst_q      <= F_ADDR;
					flash_cs_n <= 1'b0;
					flash_mosi <= f_word[31];
					f_sh_q     <= {f_word[30:0], 1'b0};
					f_bit_q    <= 5'h00;
					f_dst_q    <= !seq_req;
					f_cnt_q    <= (st_q == S_BOOT) ? 4'h1 : ENTRY_BYTES;
				end
			F_ADDR:
				if (tick_f && !flash_sck)
					flash_sck <= 1'b1;
				else if (tick_f)
				begin
					flash_sck  <= 1'b0;
					flash_mosi <= f_sh_q[31];
					f_sh_q     <= {f_sh_q[30:0], 1'b0};
					f_bit_q    <= f_bit_q + 5'h01;
					if (f_bit_q == 5'h1F)
					begin
						fst_q   <= F_DATA;
						f_bit_q <= 5'h00;
					end
				end
			F_DATA:
				if (tick_f && !flash_sck)
				begin
					if (f_bit_q == 5'h00 && f_dst_q && !stream_ok)
					begin
						fst_q      <= F_IDLE;
						flash_cs_n <= 1'b1;
					end
					else if (!(f_bit_q == 5'h00 && f_dst_q && !fifo_ready))
						flash_sck <= 1'b1;
				end
				else if (tick_f)
				begin
					flash_sck <= 1'b0;
					f_rx_q    <= {f_rx_q[6:0], fm_q};
					f_bit_q   <= (f_bit_q == 5'h07) ? 5'h00 : f_bit_q + 5'h01;
					if (f_bit_q == 5'h07 && f_dst_q)
						f_push_q <= 1'b1;
					else if (f_bit_q == 5'h07)
					begin
						f_cnt_q <= f_cnt_q - 4'h1;
						if (f_cnt_q == 4'h1)
						begin
							fst_q      <= F_IDLE;
							flash_cs_n <= 1'b1;
							f_done_q   <= 1'b1;
						end
					end
				end
			default:
				fst_q <= F_IDLE;
		endcase
	end

	// Entry bytes shift in low byte first (see R17 R18 R19)
	assign ent_w = '{dtype: ent_q[63:56], size: ent_q[55:32],
		start: ent_q[23:0]};
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ent_q <= 64'h0000000000000000;
		else if (f_byte_done && !f_dst_q)
			ent_q <= {f_rx_q[6:0], fm_q, ent_q[63:8]};
	end

	// Stream position survives index fetches made inside a sequence
	assign vm_load = st_q == S_DISPATCH && ent_w.dtype == TYPE_VMSEQ
		&& !in_vm_q;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			vm_addr_q <= 24'h000000;
			vm_push_q <= 24'h000000;
		end
		else if (vm_load)
		begin
			vm_addr_q <= ent_w.start;
			vm_push_q <= ent_w.size; // see R18
		end
		else if (f_byte_done && f_dst_q)
		begin
			vm_addr_q <= vm_addr_q + 24'h000001;
			vm_push_q <= vm_push_q - 24'h000001;
		end
	end

	vms_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.flush     (vm_load || vm_end),
		.in_valid  (f_push_q),
		.in_ready  (fifo_ready),
		.in_data   (f_rx_q),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	// Fractional divider: SYS_MHZ ticks out of every REF_MHZ cycles
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			acc_q    <= 6'h00;
			sys_tick <= 1'b0;
		end
		else
		begin
			sys_tick <= acc_q + SYS_MHZ >= REF_MHZ;
			acc_q    <= (acc_q + SYS_MHZ >= REF_MHZ)
				? acc_q + SYS_MHZ - REF_MHZ : acc_q + SYS_MHZ;
		end
	end

	// Sequence interpreter pops only while no command is complete
	assign pop = st_q == S_VM_GET && fifo_valid && vm_pop_q != 24'h0
		&& !(vm_op_q == OP_WAIT && vm_nb_q == 2'h2) && vm_nb_q != 2'h3;
	assign vm_end = (st_q == S_VM_GET && vm_pop_q == 24'h0 && in_vm_q)
		|| (st_q == S_DISPATCH && in_vm_q && ent_w.dtype == TYPE_NONE);

	// Main sequencer
	always_ff @(posedge ref_clk)
	begin
		spch_start  <= 1'b0;
		adpcm_start <= 1'b0;
		if (!rst_n)
		begin
			st_q        <= S_BOOT;
			in_vm_q     <= 1'b0;
			bank_q      <= 8'h00;
			vm_pop_q    <= 24'h000000;
			vm_nb_q     <= 2'h0;
			vm_op_q     <= 8'h00;
			vm_arg_q    <= 8'h00;
			nn_q        <= 8'h00;
			per_q       <= 25'h0000000;
			play_entry  <= '0;
			custom_code <= 1'b0;
		end
		else case (st_q)
			S_BOOT, S_IDX:
				if (seq_req)
					st_q <= (st_q == S_BOOT) ? S_BOOT_W : S_IDX_W;
			S_BOOT_W:
				if (f_done_q)
				begin
					custom_code <= ent_w.dtype == PROG_FLAG_VALUE; // see R14
					st_q        <= S_IDLE;
				end
			S_IDLE:
				if (play_take && play_bank_q != BANK_UNUSED) // see R16
				begin
					bank_q <= play_bank_q;
					st_q   <= S_IDX;
				end
			S_IDX_W:
				if (f_done_q)
					st_q <= S_DISPATCH;
			S_DISPATCH:
			begin
				st_q <= in_vm_q ? S_VM_GET : S_IDLE;
				// Each codec restarts alone; a peer codec keeps playing
				if (ent_w.dtype == TYPE_SPEECH) // see R08 R09 R19
				begin
					spch_start <= 1'b1;
					play_entry <= ent_w;
				end
				else if (ent_w.dtype == TYPE_ADPCM)
				begin
					adpcm_start <= 1'b1;
					play_entry  <= ent_w;
				end
				else if (vm_load) // see R05
				begin
					in_vm_q  <= 1'b1;
					vm_pop_q <= ent_w.size;
					vm_nb_q  <= 2'h0;
					st_q     <= S_VM_GET;
				end
				else if (vm_end) // see R20
				begin
					in_vm_q <= 1'b0;
					st_q    <= S_IDLE;
				end
			end
			S_VM_GET:
				if (vm_op_q == OP_WAIT && vm_nb_q == 2'h2) // see R06
				begin
					nn_q    <= vm_arg_q;
					vm_nb_q <= 2'h0;
					st_q    <= S_WAIT_PLAY;
				end
				else if (vm_nb_q == 2'h3)
				begin
					vm_nb_q <= 2'h0;
					bank_q  <= vm_arg_q;
					// Nested plays use the host path (see R05)
					if (vm_op_q == OP_PLAY && vm_arg_q != BANK_UNUSED)
						st_q <= S_IDX;
				end
				else if (vm_end) // see R20
				begin
					in_vm_q <= 1'b0;
					st_q    <= S_IDLE;
				end
				else if (pop)
				begin
					vm_pop_q <= vm_pop_q - 24'h000001;
					vm_nb_q  <= vm_nb_q + 2'h1;
					if (vm_nb_q == 2'h0)
						vm_op_q <= fifo_data;
					else if (vm_nb_q == 2'h1)
						vm_arg_q <= fifo_data;
				end
			S_WAIT_PLAY:
				if (!spch_busy && !adpcm_busy) // see R07
				begin
					per_q <= 25'h0000000;
					st_q  <= S_WAIT_TIME;
				end
			S_WAIT_TIME:
				if (nn_q == 8'h00)
					st_q <= S_VM_GET;
				else if (sys_tick)
				begin
					// Basic period from the prescale nibble (see R10)
					if (per_q == vms_period_len(prescale_q[7:4]) - 25'h1)
					begin
						per_q <= 25'h0000000;
						nn_q  <= nn_q - 8'h01;
					end
					else
						per_q <= per_q + 25'h0000001;
				end
			default:
				st_q <= S_IDLE;
		endcase
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_test_port_a: assert property (cmd_v && cmd_w.op == OP_PORT_READ // see R02
		&& cmd_w.arg1 == PORT_TEST_A |-> ##2 reply_q.arg1 == 8'h42)
		else $error("test port A reply wrong");
	a_test_port_b: assert property (cmd_v && cmd_w.op == OP_PORT_READ // see R03
		&& cmd_w.arg1 == PORT_TEST_B |-> ##2 reply_q.arg1 == 8'h03)
		else $error("test port B reply wrong");
	a_reply_default: assert property (!rd_armed_q // see R04
		|=> reply_q.arg1 == $past(status) && reply_q.arg2 == $past(status))
		else $error("default reply is not play status");
	a_prescale_reset: assert property ($past(!rst_n) // see R11
		|-> prescale_q == 8'h81)
		else $error("prescale reset value wrong");
	a_prescale_write: assert property (cmd_v && cmd_w.op == 8'h4F // see R12
		&& cmd_w.arg1 == 8'h96 |=> prescale_q == $past(cmd_w.arg2))
		else $error("prescale write lost");
	a_bank_zero: assert property (play_take && play_bank_q == 8'h00 // see R16
		|=> st_q == S_IDLE ##1 st_q != S_IDX)
		else $error("bank zero was fetched");
	a_wait_hold: assert property (st_q == S_WAIT_PLAY // see R07
		&& (spch_busy || adpcm_busy) |=> st_q == S_WAIT_PLAY)
		else $error("wait left while playing");
	a_vm_end: assert property (st_q == S_VM_GET && in_vm_q // see R20
		&& vm_pop_q == 24'h0 && vm_nb_q < 2'h2 |=> st_q == S_IDLE && !in_vm_q)
		else $error("sequence did not end");
	a_speech_start: assert property (st_q == S_DISPATCH // see R19
		&& ent_w.dtype == 8'h01 |=> spch_start && !adpcm_start)
		else $error("speech entry did not start");
	a_index_fetch: assert property (st_q == S_IDX && seq_req // see R15
		|-> seq_addr == 24'h008000 + 24'(bank_q) * 24'd8)
		else $error("index entry address wrong");

	c_vm_start: cover property (vm_load);
	c_wait_done: cover property (st_q == S_WAIT_TIME ##1 st_q == S_VM_GET);
	c_read_port: cover property (rd_armed_q && reply_q.arg1 == 8'h42);

endmodule : vms_top

// File: sim/vms_flash_model.sv
// Behavioural serial flash answering the read opcode from a byte map.
// Assumes mode 0 clocking from the sequencer; unset bytes read as FF.
`timescale 1ns/1ns
module vms_flash_model (
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic mosi,
	output logic      miso
);
	logic [7:0]  mem [logic [23:0]];
	logic [31:0] cmd;
	logic [23:0] a;
	int          n = 0;
	initial miso = 1'b0;
	// Released line flips so a stale bit never reads as good data
	always @(posedge cs_n) miso = ~miso;
	always @(negedge cs_n) n = 0;
	// Opcode and address MSB first, taken on the rise
	always @(posedge sck)
	begin
		if (n < 32)
			cmd = {cmd[30:0], mosi};
		n++;
	end
	// Mode 0: each data bit is launched on the fall ahead of its capture
	always @(negedge sck)
	begin
		if (n >= 32)
		begin
			a = cmd[23:0] + 24'((n - 32) / 8);
			miso = mem.exists(a) ? mem[a][7 - (n - 32) % 8] : 1'b1;
		end
	end
endmodule : vms_flash_model

// File: sim/vms_top_tb.sv
// Bench: host frames in, replies and decoder starts checked.
// Assumes the flash model holds the index table and one sequence.
`timescale 1ns/1ns
module vms_top_tb;
	import vms_pkg::*;
	logic        ref_clk, rst_n, spi_ssb_n, spi_sck, spi_mosi, spi_miso;
	logic        flash_cs_n, flash_sck, flash_mosi, flash_miso;
	logic        spch_busy, adpcm_busy, spch_start, adpcm_start;
	logic        custom_code, spi_miso_oe;
	vms_entry_s  play_entry;
	logic [23:0] rep;
	int          sb = 0;
	int          ab = 0;
	int          n;
	int          bad_count = 0;
	int          comparisons = 0;
	time         t1, t2, t3;
	localparam int          BUSY = 300;
	localparam logic [55:0] E1 = {8'h01, 24'h000010, 24'h009000};
	localparam logic [55:0] E3 = {8'h02, 24'h000020, 24'h009200};

	vms_top u_vms_top (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.spi_ssb_n   (spi_ssb_n),
		.spi_sck     (spi_sck),
		.spi_mosi    (spi_mosi),
		.spi_miso    (spi_miso),
		.spi_miso_oe (spi_miso_oe),
		.flash_cs_n  (flash_cs_n),
		.flash_sck   (flash_sck),
		.flash_mosi  (flash_mosi),
		.flash_miso  (flash_miso),
		.spch_busy   (spch_busy),
		.adpcm_busy  (adpcm_busy),
		.spch_start  (spch_start),
		.adpcm_start (adpcm_start),
		.play_entry  (play_entry),
		.custom_code (custom_code)
	);
	vms_flash_model u_vms_flash_model (
		.cs_n (flash_cs_n),
		.sck  (flash_sck),
		.mosi (flash_mosi),
		.miso (flash_miso)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// Decoders stay busy for a fixed span after each start
	always @(negedge ref_clk)
	begin
		sb <= spch_start === 1'b1 ? BUSY : (sb != 0 ? sb - 1 : 0);
		ab <= adpcm_start === 1'b1 ? BUSY : (ab != 0 ? ab - 1 : 0);
	end
	assign spch_busy  = sb != 0;
	assign adpcm_busy = ab != 0;

	task automatic cyc(input int c);
		repeat (c) @(negedge ref_clk);
	endtask : cyc

	task automatic chk(input logic [55:0] s, e, input string m);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask : chk

	// One frame, MSB first; miso read at the end of each high level
	task automatic xfer(input logic [7:0] op, a1, a2,
		output logic [23:0] r);
		logic [23:0] tx;
		tx = {op, a1, a2};
		spi_ssb_n = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			spi_mosi = tx[i];
			cyc(6);
			spi_sck = 1'b1;
			cyc(6);
			r[i] = spi_miso;
			spi_sck = 1'b0;
		end
		cyc(6);
		chk(spi_miso_oe, 1'b1, "reply not driven");
		spi_ssb_n = 1'b1;
		cyc(8);
		chk(spi_miso_oe, 1'b0, "reply not released");
	endtask : xfer

	task automatic put(input logic [23:0] a, input logic [7:0] b[$]);
		foreach (b[i]) u_vms_flash_model.mem[a + 24'(i)] = b[i];
	endtask : put

	// Bounded wait for a start pulse, then its entry is checked
	task automatic wait_pulse(input bit ad, input logic [55:0] e,
		output time t);
		int k;
		for (k = 0; k < 7000 && (ad ? adpcm_start : spch_start) !== 1'b1;
			k++) @(negedge ref_clk);
		t = $time;
		chk(k < 7000, 1'b1, "no start");
		chk(play_entry, e, "play entry");
		@(negedge ref_clk);
	endtask : wait_pulse

	task automatic quiet(output int c);
		c = 0;
		repeat (3000)
		begin
			@(negedge ref_clk);
			c += int'(spch_start === 1'b1) + int'(adpcm_start === 1'b1);
		end
	endtask : quiet

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	initial
	begin
		cyc(60000);
		bad_count++;
		final_report();
	end

	initial
	begin
		rst_n = 1'b0;
		spi_ssb_n = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
		put(24'h000000, {8'h02});
		put(24'h008000, {8'h00, 8'h90, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h01});
		put(24'h008008, {8'h00, 8'h90, 8'h00, 8'hAA, 8'h10, 8'h00, 8'h00, 8'h01});
		put(24'h008010, {8'h00, 8'h91, 8'h00, 8'h00, 8'h0B, 8'h00, 8'h00, 8'h40});
		put(24'h008018, {8'h00, 8'h92, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h02});
		put(24'h009100, {8'h50, 8'h01, 8'h00, 8'h50, 8'h03, 8'h00, 8'h57,
			8'h01, 8'h50, 8'h03, 8'h00, 8'h50, 8'h01, 8'h00});
		cyc(5);
		rst_n = 1'b1;
		for (n = 0; n < 2000 && custom_code !== 1'b1; n++) cyc(1);
		chk(custom_code, 1'b1, "custom flag");
		$display("test boot done");
		xfer(OP_PORT_READ, PORT_TEST_A, 8'h00, rep);
		chk(rep[15:8], 8'h00, "status default");
		xfer(OP_PORT_READ, PORT_TEST_B, ADDR_PRESCALE, rep);
		chk(rep[15:8], TEST_A_VALUE, "port one");
		xfer(OP_PORT_WRITE, ADDR_PRESCALE, 8'h01, rep);
		chk(rep[15:0], {TEST_B_VALUE, PRESCALE_RESET}, "ports");
		xfer(OP_WAIT, 8'h00, 8'h00, rep);
		chk(rep[7:0], 8'h01, "prescale write");
		$display("test ports done");
		xfer(OP_PLAY, 8'h01, 8'h00, rep);
		wait_pulse(1'b0, E1, t1);
		xfer(OP_PLAY, BANK_UNUSED, 8'h00, rep);
		quiet(n);
		chk(n, 0, "bank zero played");
		$display("test plays done");
		// Sequence: speech, ADPCM, wait one period, ADPCM, then stop
		xfer(OP_PLAY, 8'h02, 8'h00, rep);
		wait_pulse(1'b0, E1, t1);
		wait_pulse(1'b1, E3, t2);
		chk((t2 - t1) / 20 < 2000, 1'b1, "not together");
		wait_pulse(1'b1, E3, t3);
		n = int'((t3 - t2) / 20);
		chk(n >= BUSY + 512 * REF_MHZ / SYS_MHZ && n < 6500, 1'b1,
			"wait span");
		quiet(n);
		chk(n, 0, "sequence overran");
		$display("test sequence done");
		final_report();
	end
endmodule : vms_top_tb
